// [tb/quad_switch_checker.sv]
// concurrent checks on the ports of the quad switch serial diagnosis block
`timescale 1ns/100ps
module quad_switch_checker #(
  parameter int FAULT_FILTER_CYCLES = quad_switch_pkg::FAULT_FILTER_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // watched ports
  input wire logic i_cs_n,
  input wire logic [3:0] i_overload_sense,
  input wire logic [3:0] i_overtemp_sense,
  input wire logic o_so_oe,
  input wire logic [3:0] o_channel_on,
  input wire logic o_fault_n,
  input wire quad_switch_pkg::diag_flags_s o_diag_flags,
  input wire logic [3:0] o_protection_diag_flag,
  input wire quad_switch_pkg::frame_t o_input_matrix,
  input wire logic o_frame_accepted
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_oe_follows_cs: assert property (o_so_oe == !i_cs_n)
    else $error("serial output enable differs from select");
  a_fault_pin_flags: assert property (o_fault_n == !(|o_diag_flags))
    else $error("fault output does not match flags");
  a_prot_combines: assert property (
    o_protection_diag_flag == (o_diag_flags.overload | o_diag_flags.overtemp))
    else $error("protection flag is not the combined flag");
  a_accept_after_cs: assert property (o_frame_accepted |-> i_cs_n && $past(i_cs_n, 3))
    else $error("frame accepted while selected");
  a_flags_clear_valid: assert property (|($past(o_diag_flags) & ~o_diag_flags) |->
    ##[0:2] o_frame_accepted or $past(o_frame_accepted))
    else $error("flags cleared without a valid frame");
  a_matrix_on_accept: assert property (!$stable(o_input_matrix) |-> ##[0:1] o_frame_accepted)
    else $error("matrix changed without a valid frame");
  a_hot_channel_off: assert property (
    (o_channel_on & $past(i_overtemp_sense, 3) & $past(i_overtemp_sense, 4)) == 4'h0)
    else $error("hot channel still on");
  a_hot_flag_set: assert property (
    (~o_diag_flags.overtemp & $past(i_overtemp_sense, 3) & $past(i_overtemp_sense, 4)) == 4'h0)
    else $error("over-temperature flag not set");
  a_filter_waits: assert property ((o_diag_flags.overload & ~$past(o_diag_flags.overload) &
    ~$past(i_overload_sense, FAULT_FILTER_CYCLES)) == 4'h0)
    else $error("over-load flag set before filter time");
endmodule

// [tb/quad_switch_spi_diag_test.sv]
// self-checking bench of the quad switch serial diagnosis block
`timescale 1ns/100ps
module quad_switch_spi_diag_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] par = 4'h0;
  logic pol = 1'b1;
  logic [3:0] ol = 4'h0;
  logic [3:0] ot = 4'h0;
  logic [3:0] op = 4'h0;
  logic [3:0] sg = 4'h0;
  logic [15:0] q;
  wire sclk, cs_n, si, so, so_oe, so_line, fault_n, comb, acc;
  wire [3:0] ch_on, prot, ser_on;
  wire quad_switch_pkg::diag_flags_s flags;
  wire quad_switch_pkg::frame_t matrix;
  int errors = 0;
  int cmp_count = 0;
  int bad_len [2] = '{0, 7};

  assign so_line = so_oe ? so : 1'bz;

  quad_switch_spi_diag #(.FAULT_FILTER_CYCLES(20)) u_quad_switch_spi_diag (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_spi_clk(sclk), .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_parallel_channel_input(par),
    .i_input_polarity_select(pol), .i_overload_sense(ol), .i_overtemp_sense(ot), .i_open_load_sense(op),
    .i_short_ground_sense(sg), .o_channel_on(ch_on), .o_fault_n(fault_n), .o_diag_flags(flags),
    .o_protection_diag_flag(prot), .o_input_matrix(matrix), .o_input_combine_select(comb),
    .o_serial_channel_on_bit(ser_on), .o_frame_accepted(acc));

  spi_master_model u_master (.o_spi_clk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so_line));

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic frame(input int n, input logic [15:0] d);
    int k;
    k = 0;
    u_master.xfer(n, d, q);
    while (acc !== 1'b1 && k < 100)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 100)
    begin
      errors++;
      $display("Error frame_accepted expected 1 seen %b", acc);
      stop_test();
    end
    repeat (10) @(negedge clk);
  endtask

  task automatic hold_faults(input logic [3:0] l, input logic [3:0] s);
    ol = l;
    op = 4'h4;
    sg = s;
    repeat (40) @(negedge clk);
    ol = 4'h0;
    op = 4'h0;
    sg = 4'h0;
    repeat (4) @(negedge clk);
  endtask

  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    check("matrix", 16'h0000, {8'h00, matrix});
    check("fault_n", 16'h0001, {15'h0000, fault_n});
    check("channel_on", 16'h0000, {12'h000, ch_on});
    frame(8, 16'h0005);
    check("matrix", 16'h0005, {8'h00, matrix});
    check("channel_on", 16'h0005, {12'h000, ch_on});
    foreach (bad_len[i])
    begin
      u_master.xfer(bad_len[i], 16'h003f, q);
      repeat (20) @(negedge clk);
    end
    check("matrix", 16'h0005, {8'h00, matrix});
    check("serial_on", 16'h0005, {12'h000, ser_on});
    frame(8, 16'h0041);
    check("combine", 16'h0001, {15'h0000, comb});
    par = 4'h3;
    repeat (6) @(negedge clk);
    check("channel_on", 16'h0001, {12'h000, ch_on});
    pol = 1'b0;
    par = 4'hc;
    repeat (6) @(negedge clk);
    check("channel_on", 16'h0001, {12'h000, ch_on});
    par = 4'h0;
    repeat (6) @(negedge clk);
    check("channel_on", 16'h0005, {12'h000, ch_on});
    hold_faults(4'h2, 4'h8);
    check("flags", 16'h2048, flags);
    check("protection", 16'h0002, {12'h000, prot});
    check("fault_n", 16'h0000, {15'h0000, fault_n});
    frame(16, 16'h5ac1);
    check("read_page0", 16'h245a, q);
    check("flags", 16'h0000, flags);
    hold_faults(4'h2, 4'h8);
    u_master.xfer(7, 16'h0000, q);
    repeat (20) @(negedge clk);
    check("flags_kept", 16'h2048, flags);
    frame(8, 16'h00c2);
    check("read_page1", 16'h0082, q);
    ot = 4'h1;
    repeat (6) @(negedge clk);
    check("channel_on", 16'h0004, {12'h000, ch_on});
    check("overtemp", 16'h0001, {12'h000, flags.overtemp});
    ot = 4'h0;
    repeat (6) @(negedge clk);
    check("channel_on", 16'h0005, {12'h000, ch_on});
    frame(8, 16'h00c0);
    check("read_page2", 16'h0010, q);
    check("flags", 16'h0000, flags);
    frame(8, 16'h0080);
    check("matrix", 16'h0000, {8'h00, matrix});
    check("combine", 16'h0000, {15'h0000, comb});
    check("serial_on", 16'h0000, {12'h000, ser_on});
    stop_test();
  end
endmodule

bind quad_switch_spi_diag quad_switch_checker #(.FAULT_FILTER_CYCLES(FAULT_FILTER_CYCLES)) u_checker (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n), .i_overload_sense(i_overload_sense),
  .i_overtemp_sense(i_overtemp_sense), .o_so_oe(o_so_oe), .o_channel_on(o_channel_on), .o_fault_n(o_fault_n),
  .o_diag_flags(o_diag_flags), .o_protection_diag_flag(o_protection_diag_flag), .o_input_matrix(o_input_matrix),
  .o_frame_accepted(o_frame_accepted));

// [tb/spi_master_model.sv]
// serial master on the far side of the link: 48 ns clock, msb first
`timescale 1ns/100ps
module spi_master_model (
  // link outputs
  output logic o_spi_clk,
  output logic o_cs_n,
  output logic o_si,
  // link input
  input wire logic i_so
);
  initial
  begin
    o_spi_clk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  // clock stays low at both select edges, select rises to end every access
  task automatic xfer(input int n, input logic [15:0] d, output logic [15:0] q);
    q = 16'h0000;
    o_cs_n = 1'b0;
    #260;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_spi_clk = 1'b1;
      #2 o_si = d[i];
      #22 o_spi_clk = 1'b0;
      q = {q[14:0], i_so};
      #24;
    end
    #250 o_cs_n = 1'b1;
    o_si = ~o_si;
  endtask
endmodule

// [verilog/fault_filter.sv]
// per-bit filter: output high once input stayed high longer than the filter time
`timescale 1ns/100ps
module fault_filter #(
  parameter int WIDTH = 4,
  parameter int CYCLES = 5500
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // conditions
  input wire logic [WIDTH-1:0] i_raw,
  output logic [WIDTH-1:0] o_recognized
);

  localparam int CW = $clog2(CYCLES + 2);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES + 1);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic [CW-1:0] count_reg;
      wire at_limit = (count_reg == LIMIT);
      always_ff @(posedge i_core_clk)
      begin
        if (!i_reset_n || !i_raw[g])
          count_reg <= '0;
        else if (!at_limit)
          count_reg <= count_reg + CW'(1);
      end
      assign o_recognized[g] = at_limit;
    end
  endgenerate

endmodule

// [verilog/level_sync.sv]
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule

// [verilog/quad_switch_pkg.sv]
// shared constants and types of the quad switch serial diagnosis block
package quad_switch_pkg;

  // sizes
  localparam int CHANNELS = 4;
  localparam int FRAME_BITS = 8;
  localparam int COUNT_BITS = 3;

  // timing
  localparam int CORE_CLK_MHZ = 50;
  localparam int FAULT_FILTER_US = 110;
  localparam int FAULT_FILTER_CYCLES = FAULT_FILTER_US * CORE_CLK_MHZ;

  // frame layout: control field on top, data field below
  localparam int CMD_POS = 6;
  localparam int CMD_WIDTH = 2;
  localparam int COMBINE_POS = 0;
  localparam int PAGE_POS = 0;
  localparam int PAGE_WIDTH = 2;

  // commands
  localparam logic [CMD_WIDTH-1:0] CMD_CHANNEL = 2'h0;
  localparam logic [CMD_WIDTH-1:0] CMD_COMBINE = 2'h1;
  localparam logic [CMD_WIDTH-1:0] CMD_SLEEP = 2'h2;
  localparam logic [CMD_WIDTH-1:0] CMD_PAGE = 2'h3;

  // diagnosis pages
  localparam logic [PAGE_WIDTH-1:0] PAGE_PROT_OPEN = 2'h0;
  localparam logic [PAGE_WIDTH-1:0] PAGE_SHORT_LOAD = 2'h1;
  localparam logic [PAGE_WIDTH-1:0] PAGE_TEMP = 2'h2;

  // reset values
  localparam logic COMBINE_RESET = 1'b0;
  localparam logic [CHANNELS-1:0] SERIAL_ON_RESET = 4'h0;
  localparam logic [PAGE_WIDTH-1:0] PAGE_RESET = 2'h0;
  localparam logic [FRAME_BITS-1:0] MATRIX_RESET = 8'h00;
  localparam logic [COUNT_BITS-1:0] COUNT_RESET = 3'h0;
  localparam logic [COUNT_BITS-1:0] COUNT_FIRST = 3'h1;

  typedef logic [FRAME_BITS-1:0] frame_t;

  typedef struct packed {
    logic [CHANNELS-1:0] overload;
    logic [CHANNELS-1:0] overtemp;
    logic [CHANNELS-1:0] open_load;
    logic [CHANNELS-1:0] short_ground;
  } diag_flags_s;

  typedef struct packed {
    frame_t data;
    logic [COUNT_BITS-1:0] bit_count;
    logic frame_id;
  } spi_frame_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FRAME = 3'b010,
    ST_END = 3'b100
  } frame_state_e;

endpackage

// [verilog/quad_switch_spi_diag.sv]
// serial slave and fault diagnosis of a four-channel low-side switch
//
// Function
// - filtered over-load sets over-load flag
// - valid frame end clears over-load flag
// - over-temperature: channel off, flag set, unfiltered
// - channel back on once sensor clears
// - valid frame end clears over-temperature flag
// - protection flag combines over-load and over-temperature
// - open-load result kept in own flag
// - short-to-ground result kept in own flag
// - faults except temperature need filter time
// - flags latched, readable, drive fault output
// - chip select falling starts slave access
// - sample input on fall, output on rise
// - accept only nonzero multiples of eight clocks
// - power-on reset and sleep restore defaults
// - chip select high: ignore, output released
// - chip select falling loads diagnosis word
// - valid end copies frame unless sleep, clears flags
// - words travel most significant bit first
// - eight-bit frame: control then data
// - shift register passes bits for chaining
// - combine select ORs or ANDs inputs
// - polarity select sets parallel input level
`timescale 1ns/100ps
module quad_switch_spi_diag #(
  parameter int CHANNELS = quad_switch_pkg::CHANNELS,
  parameter int FAULT_FILTER_CYCLES = quad_switch_pkg::FAULT_FILTER_CYCLES
) (
  // core clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // serial link
  input wire logic i_spi_clk,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // parallel control
  input wire logic [CHANNELS-1:0] i_parallel_channel_input,
  input wire logic i_input_polarity_select,
  // sensor conditions
  input wire logic [CHANNELS-1:0] i_overload_sense,
  input wire logic [CHANNELS-1:0] i_overtemp_sense,
  input wire logic [CHANNELS-1:0] i_open_load_sense,
  input wire logic [CHANNELS-1:0] i_short_ground_sense,
  // channel drive and status
  output logic [CHANNELS-1:0] o_channel_on,
  output logic o_fault_n,
  output quad_switch_pkg::diag_flags_s o_diag_flags,
  output logic [CHANNELS-1:0] o_protection_diag_flag,
  output quad_switch_pkg::frame_t o_input_matrix,
  output logic o_input_combine_select,
  output logic [CHANNELS-1:0] o_serial_channel_on_bit,
  output logic o_frame_accepted
);

  localparam int FB = quad_switch_pkg::FRAME_BITS;
  localparam int CB = quad_switch_pkg::COUNT_BITS;

  // diagnosis word offered on a page
  function automatic quad_switch_pkg::frame_t diag_word(
    input logic [quad_switch_pkg::PAGE_WIDTH-1:0] page,
    input quad_switch_pkg::diag_flags_s f
  );
    quad_switch_pkg::frame_t w;
    w = '0;
    if (page == quad_switch_pkg::PAGE_PROT_OPEN)
      w = {f.overload | f.overtemp, f.open_load};
    else if (page == quad_switch_pkg::PAGE_SHORT_LOAD)
      w = {f.short_ground, f.overload};
    else if (page == quad_switch_pkg::PAGE_TEMP)
      w = {f.overtemp, 4'h0};
    return w;
  endfunction

  // ---------------- core-domain declarations ----------------
  logic cs_sync;
  logic [CHANNELS-1:0] par_sync;
  logic pol_sync;
  logic [CHANNELS-1:0] ovl_sync;
  logic [CHANNELS-1:0] ot_sync;
  logic [CHANNELS-1:0] ol_sync;
  logic [CHANNELS-1:0] sg_sync;
  logic [CHANNELS-1:0] ovl_rec;
  logic [CHANNELS-1:0] ol_rec;
  logic [CHANNELS-1:0] sg_rec;

  quad_switch_pkg::frame_state_e state_reg;
  quad_switch_pkg::frame_state_e state_next;
  quad_switch_pkg::frame_t snapshot_reg;
  logic start_tog_reg;
  quad_switch_pkg::diag_flags_s flags_reg;
  quad_switch_pkg::diag_flags_s flags_next;
  quad_switch_pkg::frame_t matrix_reg;
  logic combine_reg;
  logic [CHANNELS-1:0] serial_on_reg;
  logic [quad_switch_pkg::PAGE_WIDTH-1:0] page_reg;
  logic accepted_reg;
  logic armed_reg;
  logic [CHANNELS-1:0] prot_reg;
  logic fault_n_reg;

  // ---------------- link-domain declarations ----------------
  logic loaded_reg;
  logic so_valid_reg;
  logic so_bit_reg;
  quad_switch_pkg::spi_frame_s link_reg;
  quad_switch_pkg::frame_t link_cur;

  // ---------------- pin synchronisers ----------------
  level_sync #(.WIDTH(2 + 5 * CHANNELS)) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_cs_n, i_input_polarity_select, i_parallel_channel_input,
              i_overload_sense, i_overtemp_sense, i_open_load_sense, i_short_ground_sense}),
    .o_sync({cs_sync, pol_sync, par_sync, ovl_sync, ot_sync, ol_sync, sg_sync})
  );

  // ---------------- fault filters ----------------
  // over-temperature bypasses the filter
  fault_filter #(.WIDTH(3 * CHANNELS), .CYCLES(FAULT_FILTER_CYCLES)) u_filter (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_raw({ovl_sync, ol_sync, sg_sync}),
    .o_recognized({ovl_rec, ol_rec, sg_rec})
  );

  // ---------------- link domain ----------------
  // before the first falling edge the outgoing word is the snapshot
  assign link_cur = loaded_reg ? link_reg.data : snapshot_reg;

  // loaded flag and output state are framed by chip select itself
  always_ff @(negedge i_spi_clk or posedge i_cs_n)
  begin
    if (i_cs_n)
      loaded_reg <= 1'b0;
    else
      loaded_reg <= 1'b1;
  end

  // sample on the falling edge, shifting msb first; the frame record
  // persists after chip select rises so the core can read it stably
  always_ff @(negedge i_spi_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      link_reg.data <= '0;
      link_reg.bit_count <= quad_switch_pkg::COUNT_RESET;
      // equal to the reset frame id, so a clockless first frame is refused
      link_reg.frame_id <= 1'b1;
    end
    else if (!i_cs_n)
    begin
      link_reg.data <= {link_cur[FB-2:0], i_si};
      link_reg.bit_count <= loaded_reg ? link_reg.bit_count + CB'(1)
                                       : quad_switch_pkg::COUNT_FIRST;
      link_reg.frame_id <= loaded_reg ? link_reg.frame_id : start_tog_reg;
    end
  end

  // output changes on the rising edge only
  always_ff @(posedge i_spi_clk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      so_valid_reg <= 1'b0;
      so_bit_reg <= 1'b0;
    end
    else
    begin
      so_valid_reg <= 1'b1;
      so_bit_reg <= link_cur[FB-1];
    end
  end

  assign o_so = so_valid_reg ? so_bit_reg : snapshot_reg[FB-1];
  assign o_so_oe = ~i_cs_n;

  // ---------------- frame sequencing (core) ----------------
  wire frame_start = (state_reg == quad_switch_pkg::ST_IDLE) && armed_reg && !cs_sync;
  wire frame_end = (state_reg == quad_switch_pkg::ST_END);
  // frame had clocks when the link stamped this frame's id
  wire frame_clocked = (link_reg.frame_id == start_tog_reg);
  wire frame_valid = frame_end && frame_clocked &&
                     (link_reg.bit_count == quad_switch_pkg::COUNT_RESET);
  wire [quad_switch_pkg::CMD_WIDTH-1:0] cmd =
    link_reg.data[quad_switch_pkg::CMD_POS +: quad_switch_pkg::CMD_WIDTH];
  wire cmd_channel = frame_valid && (cmd == quad_switch_pkg::CMD_CHANNEL);
  wire cmd_combine = frame_valid && (cmd == quad_switch_pkg::CMD_COMBINE);
  wire cmd_sleep = frame_valid && (cmd == quad_switch_pkg::CMD_SLEEP);
  wire cmd_page = frame_valid && (cmd == quad_switch_pkg::CMD_PAGE);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      quad_switch_pkg::ST_IDLE:
        if (frame_start)
          state_next = quad_switch_pkg::ST_FRAME;
      quad_switch_pkg::ST_FRAME:
        if (cs_sync)
          state_next = quad_switch_pkg::ST_END;
      quad_switch_pkg::ST_END:
        state_next = quad_switch_pkg::ST_IDLE;
      default:
        state_next = quad_switch_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      state_reg <= quad_switch_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // the select synchroniser leaves reset low, so frames wait until select is seen idle
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      armed_reg <= 1'b0;
    else if (cs_sync)
      armed_reg <= 1'b1;
  end

  // snapshot and frame id are held for the whole frame
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      snapshot_reg <= '0;
      start_tog_reg <= 1'b1;
    end
    else if (frame_start)
    begin
      snapshot_reg <= diag_word(page_reg, flags_reg);
      start_tog_reg <= ~start_tog_reg;
    end
  end

  // ---------------- diagnosis flags ----------------
  wire flag_clear = frame_valid;

  // a new set wins over the clear of the same cycle
  function automatic logic [CHANNELS-1:0] latch_flags(
    input logic [CHANNELS-1:0] held,
    input logic [CHANNELS-1:0] raised,
    input logic clear
  );
    return (held & ~{CHANNELS{clear}}) | raised;
  endfunction

  always_comb
  begin
    flags_next.overload = latch_flags(flags_reg.overload, ovl_rec, flag_clear);
    flags_next.overtemp = latch_flags(flags_reg.overtemp, ot_sync, flag_clear);
    flags_next.open_load = latch_flags(flags_reg.open_load, ol_rec, flag_clear);
    flags_next.short_ground = latch_flags(flags_reg.short_ground, sg_rec, flag_clear);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      flags_reg <= '0;
    else
      flags_reg <= flags_next;
  end

  // status pins come from flops that track the flag registers cycle for cycle
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      prot_reg <= '0;
      fault_n_reg <= 1'b1;
    end
    else
    begin
      prot_reg <= flags_next.overload | flags_next.overtemp;
      fault_n_reg <= ~(|flags_next);
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n || cmd_sleep)
    begin
      matrix_reg <= quad_switch_pkg::MATRIX_RESET;
      combine_reg <= quad_switch_pkg::COMBINE_RESET;
      serial_on_reg <= quad_switch_pkg::SERIAL_ON_RESET;
      page_reg <= quad_switch_pkg::PAGE_RESET;
    end
    else if (frame_valid)
    begin
      matrix_reg <= link_reg.data;
      if (cmd_channel)
        serial_on_reg <= link_reg.data[CHANNELS-1:0];
      if (cmd_combine)
        combine_reg <= link_reg.data[quad_switch_pkg::COMBINE_POS];
      if (cmd_page)
        page_reg <= link_reg.data[quad_switch_pkg::PAGE_POS +: quad_switch_pkg::PAGE_WIDTH];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      accepted_reg <= 1'b0;
    else
      accepted_reg <= frame_valid;
  end

  // ---------------- channel drive ----------------
  wire [CHANNELS-1:0] par_level = pol_sync ? par_sync : ~par_sync;
  wire [CHANNELS-1:0] combined = combine_reg ? (par_level & serial_on_reg)
                                             : (par_level | serial_on_reg);
  wire [CHANNELS-1:0] drive_next = combined & ~ot_sync;

  logic [CHANNELS-1:0] drive_reg;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      drive_reg <= '0;
    else
      drive_reg <= drive_next;
  end

  // ---------------- outputs ----------------
  assign o_channel_on = drive_reg;
  assign o_diag_flags = flags_reg;
  assign o_protection_diag_flag = prot_reg;
  assign o_fault_n = fault_n_reg;
  assign o_input_matrix = matrix_reg;
  assign o_input_combine_select = combine_reg;
  assign o_serial_channel_on_bit = serial_on_reg;
  assign o_frame_accepted = accepted_reg;

endmodule
